//--- src/ssl_supply_ctrl.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
// What this block does
// - retry field: 00 latch-off, 01 400 ms, 10 4 s, 11 12 s.
// - with retry field 00 the supply never restarts on its own.
// - blanking field: 00 5.5 ms, 01 16.5 ms, 10 55 ms, 11 165 ms.
// - dynamic blanking shortens the time only below the power-good falling threshold.
// - dynamic blanking between 9 V and 17 V uses half the time.
// - dynamic blanking below 9 V uses a quarter of the time.
// - double-limit bit and output above 18 V selects twice the limit.
// - limit-disable turns off the sense amplifier and all limiting.
// - supply enable turns on the external switch gate driver.
// - enable low holds retry, latch-off and blanking timers in reset.
// - enable pulses shorter than 200 us are ignored.
module ssl_supply_ctrl
  import ssl_pkg::*;
#(
  parameter longint BL0_CYC = SSL_BL0_CYC,
  parameter longint BL1_CYC = SSL_BL1_CYC,
  parameter longint BL2_CYC = SSL_BL2_CYC,
  parameter longint BL3_CYC = SSL_BL3_CYC,
  parameter longint RT1_CYC = SSL_RT1_CYC,
  parameter longint RT2_CYC = SSL_RT2_CYC,
  parameter longint RT3_CYC = SSL_RT3_CYC,
  parameter longint GLITCH_CYC = SSL_GLITCH_CYC
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          ce,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire ssl_pkg::ssl_sense_type sense,
  output ssl_pkg::ssl_drive_type      drive
);
  import ssl_pkg::*;

  typedef struct packed {
    logic [7:0]    cfg;
    logic          wr_pend;
    logic          rd_pend;
    logic [7:0]    wr_addr;
    logic [31:0]   rdata;
    ssl_state_type st;
    logic [31:0]   bl_cnt;
    logic [31:0]   rt_cnt;
  } ssl_state_all_type;

  ssl_state_all_type s_r;
  ssl_state_all_type s_nxt;

  logic        en_filt;
  logic [1:0]  rt_sel;
  logic [1:0]  bl_sel;
  logic [31:0] bl_full;
  logic [31:0] bl_eff;
  logic [31:0] rt_len;
  logic        lim_active;
  logic        addr_ok;
  logic [7:0]  status;

  ssl_enable_filter #(
    .HOLD_CYC (32'(GLITCH_CYC))
  ) u_en_filter (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .raw_in   (s_r.cfg[SSL_EN_BIT]),
    .filt_out (en_filt)
  );

  assign rt_sel     = s_r.cfg[SSL_RT_LSB +: 2];
  assign bl_sel     = s_r.cfg[SSL_BL_LSB +: 2];
  assign lim_active = !s_r.cfg[SSL_DIS_BIT];

  // programmed blanking length
  always_comb begin
    unique case (bl_sel)
      2'h0: bl_full = 32'(BL0_CYC);
      2'h1: bl_full = 32'(BL1_CYC);
      2'h2: bl_full = 32'(BL2_CYC);
      2'h3: bl_full = 32'(BL3_CYC);
    endcase
  end

  // dynamic shortening by output voltage
  always_comb begin
    bl_eff = bl_full;
    if (s_r.cfg[SSL_DYN_BIT] && sense.below_pg_fall) begin
      if (sense.below_9v) begin
        bl_eff = bl_full >> 2;
      end else begin
        bl_eff = bl_full >> 1;
      end
    end
    if (bl_eff == 32'h0000_0000) begin
      bl_eff = 32'h0000_0001;
    end
  end

  // retry period
  always_comb begin
    unique case (rt_sel)
      2'h0: rt_len = 32'h0000_0000;
      2'h1: rt_len = 32'(RT1_CYC);
      2'h2: rt_len = 32'(RT2_CYC);
      2'h3: rt_len = 32'(RT3_CYC);
    endcase
  end

  assign addr_ok = (haddr[7:0] == SSL_CFG_OFFSET) || (haddr[7:0] == SSL_STAT_OFFSET);
  assign status  = {4'h0, s_r.st == SSL_LATCHED, s_r.st == SSL_RETRY, drive.switch_gate_drive, en_filt};

  always_comb begin
    s_nxt = s_r;
    // bus data phase
    s_nxt.wr_pend = 1'b0;
    s_nxt.rd_pend = 1'b0;
    if (s_r.wr_pend && (s_r.wr_addr == SSL_CFG_OFFSET)) begin
      s_nxt.cfg = hwdata[7:0];
    end
    // bus address phase
    if (hsel && hready && htrans[1]) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.rd_pend = !hwrite;
      s_nxt.wr_addr = haddr[7:0];
      s_nxt.rdata   = 32'h0000_0000;
      if (!hwrite && addr_ok) begin
        if (haddr[7:0] == SSL_CFG_OFFSET) begin
          s_nxt.rdata = {24'h000000, s_nxt.cfg};
        end else begin
          s_nxt.rdata = {24'h000000, status};
        end
      end
    end

    // supply state machine
    if (!en_filt) begin
      s_nxt.st     = SSL_OFF;
      s_nxt.bl_cnt = 32'h0000_0000;
      s_nxt.rt_cnt = 32'h0000_0000;
    end else begin
      unique case (s_r.st)
        SSL_OFF: begin
          s_nxt.st     = SSL_ON;
          s_nxt.bl_cnt = 32'h0000_0000;
        end
        SSL_ON: begin
          if (lim_active && sense.cur_at_limit) begin
            if (s_r.bl_cnt + 32'h0000_0001 >= bl_eff) begin
              s_nxt.bl_cnt = 32'h0000_0000;
              s_nxt.rt_cnt = 32'h0000_0000;
              if (rt_sel == SSL_RT_LATCH) begin
                s_nxt.st = SSL_LATCHED;
              end else begin
                s_nxt.st = SSL_RETRY;
              end
            end else begin
              s_nxt.bl_cnt = s_r.bl_cnt + 32'h0000_0001;
            end
          end else begin
            s_nxt.bl_cnt = 32'h0000_0000;
          end
        end
        SSL_RETRY: begin
          if (rt_sel == SSL_RT_LATCH) begin
            s_nxt.st = SSL_LATCHED;
          end else if (s_r.rt_cnt + 32'h0000_0001 >= rt_len) begin
            s_nxt.st     = SSL_ON;
            s_nxt.rt_cnt = 32'h0000_0000;
          end else begin
            s_nxt.rt_cnt = s_r.rt_cnt + 32'h0000_0001;
          end
        end
        SSL_LATCHED: begin
          s_nxt.st = SSL_LATCHED;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r     <= '0;
      s_r.cfg <= SSL_CFG_RESET;
      s_r.st  <= SSL_OFF;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    drive.switch_gate_drive = en_filt && (s_r.st == SSL_ON);
    drive.sense_amp_on      = lim_active;
    drive.limit_double      = s_r.cfg[SSL_DBL_BIT] && sense.above_18v;
  end

  assign hrdata    = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : ssl_supply_ctrl

//--- src/ssl_pkg.sv
package ssl_pkg;

  // register map
  localparam logic [7:0] SSL_CFG_OFFSET  = 8'h18;
  localparam logic [7:0] SSL_STAT_OFFSET = 8'h1C;
  localparam logic [7:0] SSL_CFG_RESET   = 8'h00;

  // configuration field positions
  localparam int SSL_RT_LSB   = 6;
  localparam int SSL_DYN_BIT  = 5;
  localparam int SSL_BL_LSB   = 3;
  localparam int SSL_DBL_BIT  = 2;
  localparam int SSL_DIS_BIT  = 1;
  localparam int SSL_EN_BIT   = 0;

  // clock
  localparam longint SSL_CLK_HZ = 125000000;

  // times in microseconds, figures as printed
  localparam longint SSL_GLITCH_US = 200;
  localparam longint SSL_BL0_US    = 5500;
  localparam longint SSL_BL1_US    = 16500;
  localparam longint SSL_BL2_US    = 55000;
  localparam longint SSL_BL3_US    = 165000;
  localparam longint SSL_RT1_US    = 400000;
  localparam longint SSL_RT2_US    = 4000000;
  localparam longint SSL_RT3_US    = 12000000;

  // cycle counts, least times round up
  localparam longint SSL_GLITCH_CYC = (SSL_GLITCH_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_BL0_CYC    = (SSL_BL0_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_BL1_CYC    = (SSL_BL1_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_BL2_CYC    = (SSL_BL2_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_BL3_CYC    = (SSL_BL3_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_RT1_CYC    = (SSL_RT1_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_RT2_CYC    = (SSL_RT2_US * SSL_CLK_HZ + 999999) / 1000000;
  localparam longint SSL_RT3_CYC    = (SSL_RT3_US * SSL_CLK_HZ + 999999) / 1000000;

  // retry field codes
  localparam logic [1:0] SSL_RT_LATCH = 2'h0;

  // analogue condition inputs
  typedef struct packed {
    logic cur_at_limit;
    logic below_pg_fall;
    logic below_9v;
    logic above_18v;
  } ssl_sense_type;

  // analogue control outputs
  typedef struct packed {
    logic switch_gate_drive;
    logic sense_amp_on;
    logic limit_double;
  } ssl_drive_type;

  typedef enum logic [1:0] {
    SSL_OFF,
    SSL_ON,
    SSL_RETRY,
    SSL_LATCHED
  } ssl_state_type;

endpackage : ssl_pkg

//--- src/ssl_enable_filter.sv
`timescale 1ns/10ps
module ssl_enable_filter
  import ssl_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 32'(SSL_GLITCH_CYC)
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic raw_in,
  output logic      filt_out
);

  typedef struct packed {
    logic        out;
    logic [15:0] cnt;
  } ssl_filt_type;

  ssl_filt_type s_r;
  ssl_filt_type s_nxt;

  // output follows the raw level only after it has differed for the hold time
  always_comb begin
    s_nxt = s_r;
    if (raw_in == s_r.out) begin
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt >= 16'(HOLD_CYC - 1)) begin
      s_nxt.out = raw_in;
      s_nxt.cnt = 16'h0000;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign filt_out = s_r.out;

endmodule : ssl_enable_filter

//--- verification/ssl_supply_ctrl_props.sv
`timescale 1ns/10ps
module ssl_supply_ctrl_props
  import ssl_pkg::*;
(
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   ce,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire ssl_pkg::ssl_sense_type sense,
  input wire ssl_pkg::ssl_drive_type drive
);
  logic       wp_r;
  logic [7:0] sh_r;
  // shadow of the configuration register, fed from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r <= 1'b0;
      sh_r <= SSL_CFG_RESET;
    end else if (ce) begin
      wp_r <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == SSL_CFG_OFFSET;
      if (wp_r) begin
        sh_r <= hwdata[7:0];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence cfg_rd_s;
    ce && hsel && hready && htrans[1] && !hwrite && haddr[7:0] == SSL_CFG_OFFSET;
  endsequence
  sequence trip_s;
    sense.cur_at_limit ##1 $fell(drive.switch_gate_drive);
  endsequence
  bus_ok_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  cfg_read_a: assert property (cfg_rd_s |=> hrdata == {24'h0, sh_r}) else $error("config read differs");
  unmap_zero_a: assert property (ce && hsel && hready && htrans[1] && !hwrite && haddr[7:0] != SSL_CFG_OFFSET
    && haddr[7:0] != SSL_STAT_OFFSET |=> hrdata == 32'h0) else $error("unmapped read not zero");
  amp_follow_a: assert property (drive.sense_amp_on == !sh_r[SSL_DIS_BIT]) else $error("amp state wrong");
  dbl_follow_a: assert property (drive.limit_double == (sh_r[SSL_DBL_BIT] && sense.above_18v))
    else $error("double limit wrong");
  trip_blank_a: assert property (trip_s |-> $past(sense.cur_at_limit, 8)) else $error("trip too early");
  trip_hold_a: assert property (trip_s |=> !drive.switch_gate_drive [*8]) else $error("gate back too soon");
  rise_gap_a: assert property ($rose(drive.switch_gate_drive) |-> !$past(drive.switch_gate_drive, 8))
    else $error("gate rose too soon");
endmodule : ssl_supply_ctrl_props

bind ssl_supply_ctrl ssl_supply_ctrl_props ssl_supply_ctrl_props_inst (.hclk, .hresetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sense, .drive);

//--- verification/ssl_switch_model.sv
`timescale 1ns/10ps
module ssl_switch_model (
  input wire logic                    gate,
  input wire logic                    short_cmd,
  input wire logic                    sag_cmd,
  output ssl_pkg::ssl_sense_type      sense
);
  import ssl_pkg::*;
  // a shorted load pulls the output down and holds the current at the limit
  // fields msb first: at limit, below power-good fall, below 9 V, above 18 V
  assign sense = {gate & short_cmd, !gate | short_cmd, !gate | (short_cmd & sag_cmd), gate & !short_cmd};
endmodule : ssl_switch_model

//--- verification/test_sensor_supply_limit_timer.sv
`timescale 1ns/10ps
module test_sensor_supply_limit_timer;
  import ssl_pkg::*;
  localparam int BL0 = 40, BL1 = 120, BL2 = 400, BL3 = 1200;
  localparam int RT1 = 100, RT2 = 200, RT3 = 300, GLT = 8;
  logic          hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, short_cmd, sag_cmd;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   haddr, hwdata, hrdata, q;
  ssl_sense_type sense;
  ssl_drive_type drive;
  integer        errors, n_checks, seed, n, e;
  integer        blk [4] = '{BL0, BL1, BL2, BL3};
  integer        rty [4] = '{0, RT1, RT2, RT3};
  always #4 hclk = ~hclk;
  ssl_supply_ctrl #(.BL0_CYC(BL0), .BL1_CYC(BL1), .BL2_CYC(BL2), .BL3_CYC(BL3), .RT1_CYC(RT1), .RT2_CYC(RT2),
    .RT3_CYC(RT3), .GLITCH_CYC(GLT)) ssl_supply_ctrl_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sense, .drive);
  ssl_switch_model ssl_switch_model_inst (.gate(drive.switch_gate_drive), .short_cmd, .sag_cmd, .sense);
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    n_checks++;
    if (sn !== ex) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task automatic rdy;
    integer k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 99) begin
      k++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : bus
  task automatic wg(input logic v, input integer b);
    n = 0;
    while (drive.switch_gate_drive !== v && n < b) begin
      @(posedge hclk);
      n++;
    end
    if (drive.switch_gate_drive !== v) begin
      errors++;
      complete_run();
    end
  endtask : wg
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, hsize, htrans, haddr, hwdata, short_cmd, sag_cmd} = '0;
    ce = 1'b1;
    {errors, n_checks, seed} = {32'h0, 32'h0, 32'h49};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, SSL_CFG_OFFSET, 0);
    chk("cfg reset", {24'h0, SSL_CFG_RESET}, q);
    bus(0, 8'h20, 0);
    chk("unmapped", 32'h0, q);
    repeat (4) begin
      e = $random(seed) & 32'hFE;
      bus(1, SSL_CFG_OFFSET, e);
      bus(1, 8'h24, ~e);
      bus(0, SSL_CFG_OFFSET, 0);
      chk("cfg rw", e, q);
      chk("amp", !e[1], drive.sense_amp_on);
    end
    bus(1, SSL_CFG_OFFSET, 1);
    bus(1, SSL_CFG_OFFSET, 0);
    repeat (20) begin
      @(posedge hclk);
      chk("glitch", 0, drive.switch_gate_drive);
    end
    for (int i = 0; i < 4; i++) begin
      sag_cmd <= i[1];
      e = i * 64 + (i % 2) * 32 + i * 8 + 5;
      bus(1, SSL_CFG_OFFSET, e);
      wg(1, 40);
      chk("gate on", 1, drive.switch_gate_drive);
      chk("double", 1, drive.limit_double);
      bus(1, SSL_CFG_OFFSET, e - 1);
      bus(1, SSL_CFG_OFFSET, e);
      repeat (12) begin
        @(posedge hclk);
        chk("glitch low", 1, drive.switch_gate_drive);
      end
      short_cmd <= 1'b1;
      wg(0, 2000);
      short_cmd <= 1'b0;
      e = blk[i] / (i == 1 ? 2 : i == 3 ? 4 : 1);
      chk("blanking", 1, n >= e - 2 && n <= e + 2);
      if (i > 0) begin
        @(posedge hclk);
        if (i == 2) begin
          ce <= 1'b0;
          repeat (50) @(posedge hclk);
          ce <= 1'b1;
        end
        wg(1, 2000);
        chk("retry", 1, n >= rty[i] - 3 && n <= rty[i] + 3);
      end else begin
        repeat (400) @(posedge hclk);
        chk("latch", 0, drive.switch_gate_drive);
        bus(0, SSL_STAT_OFFSET, 0);
        chk("status", 32'h9, q);
      end
      bus(1, SSL_CFG_OFFSET, 0);
      wg(0, 40);
      chk("gate off", 0, drive.switch_gate_drive);
      repeat (12) @(posedge hclk);
    end
    complete_run();
  end
endmodule : test_sensor_supply_limit_timer
